/* File: aux_rail_monitor.sv */
/*
 * Watches the auxiliary rail good level, waits a settle time and then
 * gives one start pulse per power-up.
 * Assumes the rail level is synchronous to the clock.
 */
`include "pinstrap_consts.svh"
module aux_rail_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic rail,
    output logic rail_good,
    output logic start_pulse
);
    logic [`SETTLE_CNT_W-1:0] cnt_r;
    logic [`SETTLE_CNT_W-1:0] cnt_nxt;
    logic good_r;
    logic good_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        good_nxt = good_r;
        start_pulse = 1'b0;
        if (!rail) begin
            cnt_nxt = '0;
            good_nxt = 1'b0;
        end else if (!good_r) begin
            // Straps are not trusted until the rail has settled
            if (cnt_r == `SETTLE_CNT_W'(`SETTLE_CYCLES - 1)) begin
                good_nxt = 1'b1;
                start_pulse = 1'b1;
            end else begin
                cnt_nxt = cnt_r + `SETTLE_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            good_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            good_r <= good_nxt;
        end
    end

    assign rail_good = good_r;
endmodule : aux_rail_monitor

/* File: pinstrap_config_capture.sv */
/*
 * Pinstrap configuration capture: decodes six strap pins, loads the
 * configuration once per auxiliary rail power-up, allows later bus
 * overwrites, and gates the regulator enable.
 * Assumes converters deliver synchronous codes and a done pulse.
 */
`include "pinstrap_consts.svh"

// Overview of operation
// RULE_01: Rate strap resistor picks slew rate
// RULE_02: Rate strap voltage gives four mode bits
// RULE_03: Mode bit 7 selects DAC table
// RULE_04: Mode bit 6 selects paired interleaving
// RULE_05: Mode bit 4 enables dynamic phases
// RULE_06: Mode bit 3 selects zero load-line
// RULE_07: Transient strap resistor sets overshoot level
// RULE_08: Transient strap voltage sets undershoot level
// RULE_09: Startup strap resistor gives boot bits 3:1
// RULE_10: Startup strap voltage gives boot bits 7:4
// RULE_11: Address strap resistor bits 2:1 set softstart
// RULE_12: Address strap resistor bit 0 is boot LSB
// RULE_13: Address strap voltage gives bus address
// RULE_14: Frequency strap resistor selects switching frequency
// RULE_15: Frequency strap voltage ratio is max current
// RULE_16: Limit strap codes pick one of sixteen
// RULE_17: Limit strap voltage picks ramp level
// RULE_18: Capture once at rail power-up, hold
// RULE_19: Frequency and current latched together
// RULE_20: Strap select low resistance means straps apply
// RULE_21: Bus writes may overwrite latched values
// RULE_22: Bus address only from address strap
// RULE_23: All fields load in one cycle
// RULE_24: Regulator held off until capture completes
module pinstrap_config_capture
    import pinstrap_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic AUX_3V3_RAIL,
    input wire logic STRAP_SELECT_PIN,
    output logic CONV_START,
    input wire logic CONV_DONE,
    input wire logic [`RES_W-1:0] RATE_OPTION_STRAP_RES,
    input wire logic [`ADC_W-1:0] RATE_OPTION_STRAP_DIV,
    input wire logic [`RES_W-1:0] TRANSIENT_REDUCTION_STRAP_RES,
    input wire logic [`ADC_W-1:0] TRANSIENT_REDUCTION_STRAP_DIV,
    input wire logic [`RES_W-1:0] STARTUP_VOLTAGE_STRAP_RES,
    input wire logic [`ADC_W-1:0] STARTUP_VOLTAGE_STRAP_DIV,
    input wire logic [`RES_W-1:0] ADDRESS_SOFTSTART_STRAP_RES,
    input wire logic [`ADC_W-1:0] ADDRESS_SOFTSTART_STRAP_DIV,
    input wire logic [`RES_W-1:0] FREQUENCY_CURRENT_STRAP_RES,
    input wire logic [`ADC_W-1:0] FREQUENCY_CURRENT_STRAP_DIV,
    input wire logic [`RES_W-1:0] VALLEY_LIMIT_STRAP_RES,
    input wire logic [`ADC_W-1:0] VALLEY_LIMIT_STRAP_DIV,
    input wire logic [`CFG_W-1:0] NVM_SLEW_RATE,
    input wire logic [`CFG_W-1:0] NVM_MODE,
    input wire logic [`CFG_W-1:0] NVM_OSR_LEVEL,
    input wire logic [`CFG_W-1:0] NVM_USR_LEVEL,
    input wire logic [`CFG_W-1:0] NVM_STARTUP_VID,
    input wire logic [`CFG_W-1:0] NVM_RISE_RATE,
    input wire logic [`CFG_W-1:0] NVM_FREQ_SEL,
    input wire logic [`CFG_W-1:0] NVM_MAX_CURRENT,
    input wire logic [`CFG_W-1:0] NVM_CURRENT_LIMIT,
    input wire logic [`CFG_W-1:0] NVM_RAMP_LEVEL,
    input wire logic PMBUS_WR_EN,
    input wire logic [`FIELD_SEL_W-1:0] PMBUS_WR_FIELD,
    input wire logic [`CFG_W-1:0] PMBUS_WR_DATA,
    output logic [2:0] SLEW_RATE_SEL,
    output logic [`CFG_W-1:0] MODE_SETTING,
    output logic DAC_OLD_TABLE,
    output logic PAIRED_INTERLEAVE,
    output logic DYNAMIC_PHASE_EN,
    output logic ZERO_LOAD_LINE,
    output logic [2:0] OVERSHOOT_REDUCTION_LEVEL,
    output logic [2:0] UNDERSHOOT_REDUCTION_LEVEL,
    output logic [`CFG_W-1:0] STARTUP_VOLTAGE_ID,
    output logic [1:0] SOFTSTART_RISE_RATE,
    output logic [2:0] SWITCH_FREQ_SEL,
    output logic [`CFG_W-1:0] MAX_LOAD_CURRENT,
    output logic [3:0] PER_PHASE_CURRENT_LIMIT,
    output logic [1:0] RAMP_LEVEL,
    output logic [3:0] PMBUS_TARGET_ADDR,
    output logic STRAP_MODE_ACTIVE,
    output logic CONFIG_VALID,
    output logic REGULATOR_ENABLE_ALLOW
);

    function automatic cfg_word_t field_mask(
        input logic [`FIELD_SEL_W-1:0] idx
    );
        case (idx)
            `F_SLEW: field_mask = `MASK_SLEW;
            `F_MODE: field_mask = `MASK_MODE;
            `F_OSR: field_mask = `MASK_OSR;
            `F_USR: field_mask = `MASK_USR;
            `F_STARTUP_VOLTAGE_STRAP: field_mask = `MASK_STARTUP_VOLTAGE_STRAP;
            `F_SOFTSTART_RISE_RATE: field_mask = `MASK_SOFTSTART_RISE_RATE;
            `F_FREQ: field_mask = `MASK_FREQ;
            `FREQUENCY_CURRENT_STRAP: field_mask = `MASK_MAX_LOAD_CURRENT;
            `F_OCL: field_mask = `MASK_OCL;
            `F_RAMP: field_mask = `MASK_RAMP;
            default: field_mask = `CFG_RESET;
        endcase
    endfunction : field_mask

    cap_state_t state_r;
    cap_state_t state_nxt;
    cfg_word_t cfg_r [`NUM_FIELDS];
    cfg_word_t cfg_nxt [`NUM_FIELDS];
    cfg_word_t strap_word [`NUM_FIELDS];
    cfg_word_t nvm_word [`NUM_FIELDS];
    logic [3:0] addr_r;
    logic [3:0] addr_nxt;
    logic use_strap_r;
    logic use_strap_nxt;
    logic valid_r;
    logic valid_nxt;
    logic rail_good;
    logic rail_start;
    logic [3:0] mode_code;
    logic [2:0] usr_code;
    logic [3:0] boot_hi;
    logic [3:0] addr_code;
    logic [1:0] ramp_code;
    logic wr_hit;

    aux_rail_monitor u_rail (
        .clk(CLK),
        .rst(RST),
        .rail(AUX_3V3_RAIL),
        .rail_good(rail_good),
        .start_pulse(rail_start)
    );

    strap_level_quantizer #(.OUT_W(4)) u_q_mode (
        .ratio(RATE_OPTION_STRAP_DIV),
        .level(mode_code)
    );
    strap_level_quantizer #(.OUT_W(3)) u_q_usr (
        .ratio(TRANSIENT_REDUCTION_STRAP_DIV),
        .level(usr_code)
    );
    strap_level_quantizer #(.OUT_W(4)) u_q_boot (
        .ratio(STARTUP_VOLTAGE_STRAP_DIV),
        .level(boot_hi)
    );
    strap_level_quantizer #(.OUT_W(4)) u_q_addr (
        .ratio(ADDRESS_SOFTSTART_STRAP_DIV),
        .level(addr_code)
    );
    strap_level_quantizer #(.OUT_W(2)) u_q_ramp (
        .ratio(VALLEY_LIMIT_STRAP_DIV),
        .level(ramp_code)
    );

    // Strap-derived words, laid out as the holding registers
    always_comb begin
        strap_word[`F_SLEW] = {5'h00, RATE_OPTION_STRAP_RES}; // [RULE_01]
        strap_word[`F_MODE] = {mode_code[3], mode_code[2], 1'b0,
                               mode_code[1], mode_code[0], 3'h0}; // [RULE_02]
        strap_word[`F_OSR] = {5'h00, TRANSIENT_REDUCTION_STRAP_RES}; // [RULE_07]
        strap_word[`F_USR] = {5'h00, usr_code}; // [RULE_08]
        strap_word[`F_STARTUP_VOLTAGE_STRAP] = {boot_hi, STARTUP_VOLTAGE_STRAP_RES,
                                ADDRESS_SOFTSTART_STRAP_RES[0]}; // [RULE_09] [RULE_10] [RULE_12]
        strap_word[`F_SOFTSTART_RISE_RATE] = {6'h00,
                                ADDRESS_SOFTSTART_STRAP_RES[2:1]}; // [RULE_11]
        strap_word[`F_FREQ] = {5'h00, FREQUENCY_CURRENT_STRAP_RES}; // [RULE_14]
        // Full-scale ratio of 255 maps straight to the code
        strap_word[`FREQUENCY_CURRENT_STRAP] = FREQUENCY_CURRENT_STRAP_DIV; // [RULE_15]
        strap_word[`F_OCL] = {4'h0, VALLEY_LIMIT_STRAP_RES,
                              VALLEY_LIMIT_STRAP_DIV[`ADC_W-1]}; // [RULE_16]
        strap_word[`F_RAMP] = {6'h00, ramp_code}; // [RULE_17]
    end

    always_comb begin
        nvm_word[`F_SLEW] = NVM_SLEW_RATE;
        nvm_word[`F_MODE] = NVM_MODE;
        nvm_word[`F_OSR] = NVM_OSR_LEVEL;
        nvm_word[`F_USR] = NVM_USR_LEVEL;
        nvm_word[`F_STARTUP_VOLTAGE_STRAP] = NVM_STARTUP_VID;
        nvm_word[`F_SOFTSTART_RISE_RATE] = NVM_RISE_RATE;
        nvm_word[`F_FREQ] = NVM_FREQ_SEL;
        nvm_word[`FREQUENCY_CURRENT_STRAP] = NVM_MAX_CURRENT;
        nvm_word[`F_OCL] = NVM_CURRENT_LIMIT;
        nvm_word[`F_RAMP] = NVM_RAMP_LEVEL;
    end

    // Out-of-range field selects are dropped silently
    assign wr_hit = PMBUS_WR_EN &&
        (PMBUS_WR_FIELD < `FIELD_SEL_W'(`NUM_FIELDS));

    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        use_strap_nxt = use_strap_r;
        valid_nxt = valid_r;
        CONV_START = 1'b0;
        for (int i = 0; i < `NUM_FIELDS; i++) begin
            cfg_nxt[i] = cfg_r[i];
        end
        case (state_r)
            ST_IDLE: begin
                if (rail_start) begin // [RULE_18]
                    CONV_START = 1'b1;
                    state_nxt = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (CONV_DONE) begin
                    // Whole set moves at once, never a partial mix
                    for (int i = 0; i < `NUM_FIELDS; i++) begin
                        if (STRAP_SELECT_PIN) begin // [RULE_20]
                            cfg_nxt[i] = strap_word[i] &
                                field_mask(`FIELD_SEL_W'(i)); // [RULE_23] [RULE_19]
                        end else begin
                            cfg_nxt[i] = nvm_word[i] &
                                field_mask(`FIELD_SEL_W'(i));
                        end
                    end
                    addr_nxt = addr_code; // [RULE_13] [RULE_22]
                    use_strap_nxt = STRAP_SELECT_PIN;
                    valid_nxt = 1'b1;
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                // Pins are not looked at again until the next power-up
                if (wr_hit) begin // [RULE_21]
                    cfg_nxt[PMBUS_WR_FIELD] = PMBUS_WR_DATA &
                        field_mask(PMBUS_WR_FIELD);
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // Rail loss clears valid and returns to idle so the next power-up recaptures; held values stay
        if (!rail_good && !rail_start) begin
            state_nxt = ST_IDLE;
            valid_nxt = 1'b0;
            CONV_START = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= ST_IDLE;
            addr_r <= `ADDR_RESET;
            use_strap_r <= 1'b0;
            valid_r <= 1'b0;
            for (int i = 0; i < `NUM_FIELDS; i++) begin
                cfg_r[i] <= `CFG_RESET;
            end
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            use_strap_r <= use_strap_nxt;
            valid_r <= valid_nxt;
            for (int i = 0; i < `NUM_FIELDS; i++) begin
                cfg_r[i] <= cfg_nxt[i];
            end
        end
    end

    assign SLEW_RATE_SEL = cfg_r[`F_SLEW][2:0];
    assign MODE_SETTING = cfg_r[`F_MODE];
    assign DAC_OLD_TABLE = cfg_r[`F_MODE][`MODE_DAC_BIT]; // [RULE_03]
    assign PAIRED_INTERLEAVE = cfg_r[`F_MODE][`MODE_ILV_BIT]; // [RULE_04]
    assign DYNAMIC_PHASE_EN = cfg_r[`F_MODE][`MODE_DPS_BIT]; // [RULE_05]
    assign ZERO_LOAD_LINE = cfg_r[`F_MODE][`MODE_ZLL_BIT]; // [RULE_06]
    assign OVERSHOOT_REDUCTION_LEVEL = cfg_r[`F_OSR][2:0];
    assign UNDERSHOOT_REDUCTION_LEVEL = cfg_r[`F_USR][2:0];
    assign STARTUP_VOLTAGE_ID = cfg_r[`F_STARTUP_VOLTAGE_STRAP];
    assign SOFTSTART_RISE_RATE = cfg_r[`F_SOFTSTART_RISE_RATE][1:0];
    assign SWITCH_FREQ_SEL = cfg_r[`F_FREQ][2:0];
    assign MAX_LOAD_CURRENT = cfg_r[`FREQUENCY_CURRENT_STRAP];
    assign PER_PHASE_CURRENT_LIMIT = cfg_r[`F_OCL][3:0];
    assign RAMP_LEVEL = cfg_r[`F_RAMP][1:0];
    assign PMBUS_TARGET_ADDR = addr_r;
    assign STRAP_MODE_ACTIVE = use_strap_r;
    assign CONFIG_VALID = valid_r;
    assign REGULATOR_ENABLE_ALLOW = valid_r && rail_good; // [RULE_24]

    a_conv_on_rail: assert property ( // [RULE_18]
        @(posedge CLK) disable iff (RST)
        (state_r == ST_IDLE && rail_start) |-> CONV_START ##1
        (state_r == ST_CONVERT && !CONFIG_VALID)
    ) else $error("conversion not started at rail power-up");

    a_load_slew: assert property ( // [RULE_01]
        @(posedge CLK) disable iff (RST)
        (state_r == ST_CONVERT && CONV_DONE && rail_good
         && STRAP_SELECT_PIN)
        |=> SLEW_RATE_SEL == $past(RATE_OPTION_STRAP_RES)
    ) else $error("slew rate not taken from strap");

    a_boot_vid: assert property ( // [RULE_12]
        @(posedge CLK) disable iff (RST)
        (state_r == ST_CONVERT && CONV_DONE && rail_good
         && STRAP_SELECT_PIN)
        |=> STARTUP_VOLTAGE_ID[0] == $past(ADDRESS_SOFTSTART_STRAP_RES[0])
        && STARTUP_VOLTAGE_ID[3:1] == $past(STARTUP_VOLTAGE_STRAP_RES)
    ) else $error("boot code low bits wrong");

    a_freq_max_load_current: assert property ( // [RULE_19]
        @(posedge CLK) disable iff (RST)
        (state_r == ST_CONVERT && CONV_DONE && rail_good
         && STRAP_SELECT_PIN)
        |=> MAX_LOAD_CURRENT == $past(FREQUENCY_CURRENT_STRAP_DIV)
        && SWITCH_FREQ_SEL == $past(FREQUENCY_CURRENT_STRAP_RES)
        && CONFIG_VALID
    ) else $error("frequency and current not latched together");

    a_nvm_select: assert property ( // [RULE_20]
        @(posedge CLK) disable iff (RST)
        (state_r == ST_CONVERT && CONV_DONE && rail_good
         && !STRAP_SELECT_PIN)
        |=> MAX_LOAD_CURRENT == $past(NVM_MAX_CURRENT)
        && !STRAP_MODE_ACTIVE
    ) else $error("stored setting not used in stored mode");

    a_addr_strap: assert property ( // [RULE_22]
        @(posedge CLK) disable iff (RST)
        (state_r == ST_CONVERT && CONV_DONE && rail_good)
        |=> PMBUS_TARGET_ADDR == $past(addr_code)
    ) else $error("bus address not from address strap");

    a_hold_value: assert property ( // [RULE_18]
        @(posedge CLK) disable iff (RST)
        (state_r == ST_RUN && rail_good && !PMBUS_WR_EN)
        |=> $stable(MAX_LOAD_CURRENT) && $stable(STARTUP_VOLTAGE_ID)
        && $stable(PMBUS_TARGET_ADDR)
    ) else $error("captured value changed without a write");

    a_bus_write: assert property ( // [RULE_21]
        @(posedge CLK) disable iff (RST)
        (state_r == ST_RUN && rail_good && PMBUS_WR_EN
         && PMBUS_WR_FIELD == `F_STARTUP_VOLTAGE_STRAP)
        |=> STARTUP_VOLTAGE_ID == $past(PMBUS_WR_DATA)
    ) else $error("bus write did not overwrite boot code");

    a_mode_layout: assert property ( // [RULE_02]
        @(posedge CLK) disable iff (RST)
        (MODE_SETTING & ~`MASK_MODE) == `CFG_RESET
    ) else $error("mode setting uses unmapped bits");

    a_enable_gate: assert property ( // [RULE_24]
        @(posedge CLK) disable iff (RST)
        REGULATOR_ENABLE_ALLOW |-> state_r == ST_RUN && CONFIG_VALID
    ) else $error("regulator allowed before capture");

    a_rail_loss: assert property ( // [RULE_24]
        @(posedge CLK) disable iff (RST)
        !AUX_3V3_RAIL |=> !REGULATOR_ENABLE_ALLOW ##1 !CONFIG_VALID
    ) else $error("configuration kept after rail loss");

    a_atomic_load: assert property ( // [RULE_23]
        @(posedge CLK) disable iff (RST)
        $rose(CONFIG_VALID) |-> $past(state_r) == ST_CONVERT
        && $past(CONV_DONE)
    ) else $error("valid rose without a completed conversion");

endmodule : pinstrap_config_capture

/* File: pinstrap_config_capture_bench.sv */
/*
 * Self-checking bench for the pinstrap capture block.
 * Assumes strap_network_model stands in for the straps and converters.
 */
`include "pinstrap_consts.svh"
module pinstrap_config_capture_bench import pinstrap_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MASKS [10] = '{`MASK_SLEW, `MASK_MODE,
        `MASK_OSR, `MASK_USR, `MASK_STARTUP_VOLTAGE_STRAP, `MASK_SOFTSTART_RISE_RATE, `MASK_FREQ,
        `MASK_MAX_LOAD_CURRENT, `MASK_OCL, `MASK_RAMP};
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic rail = 1'b0;
    logic sel = 1'b1;
    logic wr_en = 1'b0;
    logic [3:0] wr_field = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic [3:0] delay = 4'h9;
    logic [2:0] res_set [6];
    logic [7:0] div_set [6];
    logic [2:0] res_o [6];
    logic [7:0] div_o [6];
    logic [7:0] nvm [10];
    logic [7:0] exp_f [10];
    logic [3:0] exp_addr;
    logic conv_start, conv_done, dac, ilv, dps, zll, strap_act, valid, en;
    logic [2:0] slew, overshoot_reduction_level, undershoot_reduction_level, freq;
    logic [7:0] mode, boot, max_load_current;
    logic [1:0] softstart_rise_rate, ramp;
    logic [3:0] per_phase_current_limit, addr;
    int err_total = 0;
    int comparisons = 0;

    always #2.5 CLK = ~CLK;

    strap_network_model u_strap_network_model (.clk(CLK),
        .conv_start(conv_start), .delay(delay), .res_set(res_set),
        .div_set(div_set), .conv_done(conv_done), .res_o(res_o),
        .div_o(div_o));

    pinstrap_config_capture u_pinstrap_config_capture (.CLK(CLK), .RST(RST),
        .AUX_3V3_RAIL(rail), .STRAP_SELECT_PIN(sel),
        .CONV_START(conv_start), .CONV_DONE(conv_done),
        .RATE_OPTION_STRAP_RES(res_o[0]), .RATE_OPTION_STRAP_DIV(div_o[0]),
        .TRANSIENT_REDUCTION_STRAP_RES(res_o[1]),
        .TRANSIENT_REDUCTION_STRAP_DIV(div_o[1]),
        .STARTUP_VOLTAGE_STRAP_RES(res_o[2]),
        .STARTUP_VOLTAGE_STRAP_DIV(div_o[2]),
        .ADDRESS_SOFTSTART_STRAP_RES(res_o[3]),
        .ADDRESS_SOFTSTART_STRAP_DIV(div_o[3]),
        .FREQUENCY_CURRENT_STRAP_RES(res_o[4]),
        .FREQUENCY_CURRENT_STRAP_DIV(div_o[4]),
        .VALLEY_LIMIT_STRAP_RES(res_o[5]), .VALLEY_LIMIT_STRAP_DIV(div_o[5]),
        .NVM_SLEW_RATE(nvm[0]), .NVM_MODE(nvm[1]), .NVM_OSR_LEVEL(nvm[2]),
        .NVM_USR_LEVEL(nvm[3]), .NVM_STARTUP_VID(nvm[4]),
        .NVM_RISE_RATE(nvm[5]), .NVM_FREQ_SEL(nvm[6]),
        .NVM_MAX_CURRENT(nvm[7]), .NVM_CURRENT_LIMIT(nvm[8]),
        .NVM_RAMP_LEVEL(nvm[9]), .PMBUS_WR_EN(wr_en),
        .PMBUS_WR_FIELD(wr_field), .PMBUS_WR_DATA(wr_data),
        .SLEW_RATE_SEL(slew), .MODE_SETTING(mode), .DAC_OLD_TABLE(dac),
        .PAIRED_INTERLEAVE(ilv), .DYNAMIC_PHASE_EN(dps),
        .ZERO_LOAD_LINE(zll), .OVERSHOOT_REDUCTION_LEVEL(overshoot_reduction_level),
        .UNDERSHOOT_REDUCTION_LEVEL(undershoot_reduction_level), .STARTUP_VOLTAGE_ID(boot),
        .SOFTSTART_RISE_RATE(softstart_rise_rate), .SWITCH_FREQ_SEL(freq),
        .MAX_LOAD_CURRENT(max_load_current), .PER_PHASE_CURRENT_LIMIT(per_phase_current_limit),
        .RAMP_LEVEL(ramp), .PMBUS_TARGET_ADDR(addr),
        .STRAP_MODE_ACTIVE(strap_act), .CONFIG_VALID(valid),
        .REGULATOR_ENABLE_ALLOW(en));

    function automatic logic [7:0] quant(logic [7:0] x, int n);
        int v;
        v = (int'(x) + (1 << (8 - n)) / 2) >> (8 - n);
        if (v > (1 << n) - 1)
            v = (1 << n) - 1;
        return 8'(v);
    endfunction : quant

    function automatic logic [7:0] field(int i);
        case (i)
            0: return 8'(slew);
            1: return mode;
            2: return 8'(overshoot_reduction_level);
            3: return 8'(undershoot_reduction_level);
            4: return boot;
            5: return 8'(softstart_rise_rate);
            6: return 8'(freq);
            7: return max_load_current;
            8: return 8'(per_phase_current_limit);
            default: return 8'(ramp);
        endcase
    endfunction : field

    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tick;
        @(posedge CLK);
        #1;
    endtask : tick

    task automatic results;
        $display("Checks %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    task automatic calc_strap;
        logic [7:0] q;
        q = quant(div_set[0], 4);
        exp_f[0] = 8'(res_set[0]);
        exp_f[1] = {q[3], q[2], 1'b0, q[1], q[0], 3'h0};
        exp_f[2] = 8'(res_set[1]);
        exp_f[3] = quant(div_set[1], 3);
        q = quant(div_set[2], 4);
        exp_f[4] = {q[3:0], res_set[2], res_set[3][0]};
        exp_f[5] = 8'(res_set[3][2:1]);
        exp_f[6] = 8'(res_set[4]);
        exp_f[7] = div_set[4];
        exp_f[8] = {4'h0, res_set[5], div_set[5][7]};
        exp_f[9] = quant(div_set[5], 2);
        q = quant(div_set[3], 4);
        exp_addr = q[3:0];
    endtask : calc_strap

    task automatic check_all;
        logic [7:0] mb;
        mb = 8'({exp_f[1][7], exp_f[1][6], exp_f[1][4], exp_f[1][3]});
        for (int i = 0; i < 10; i++) begin
            chk($sformatf("field %0d", i), exp_f[i], field(i));
        end
        chk("address", 8'(exp_addr), 8'(addr));
        chk("mode bits", mb, 8'({dac, ilv, dps, zll}));
    endtask : check_all

    // Waits out the rail settle time plus conversion
    task automatic power_up;
        int n;
        n = 0;
        rail = 1'b1;
        while (valid !== 1'b1 && n < 2200) begin
            if (en !== 1'b0)
                chk("enable early", 8'h00, 8'(en));
            tick();
            n++;
        end
        chk("capture done", 8'h01, 8'(valid));
        if (valid !== 1'b1)
            results();
        chk("enable allowed", 8'h01, 8'(en));
    endtask : power_up

    task automatic write(logic [3:0] f, logic [7:0] d);
        wr_en = 1'b1;
        wr_field = f;
        wr_data = d;
        tick();
        wr_en = 1'b0;
        tick();
    endtask : write

    initial begin
        int starts;
        for (int i = 0; i < 6; i++) begin
            res_set[i] = 3'(i + 3);
            div_set[i] = 8'(8'h27 + 8'h2E * i);
        end
        for (int i = 0; i < 10; i++)
            nvm[i] = 8'hA5 ^ 8'(i * 17);
        div_set[0] = 8'h50;
        div_set[3] = 8'hF9;
        div_set[5] = 8'hFF;
        repeat (12) tick();
        RST = 1'b0;
        calc_strap();
        power_up();
        check_all();
        chk("strap mode", 8'h01, 8'(strap_act));
        // Pins move after capture; nothing may follow them
        div_set[0] = 8'hA0;
        div_set[4] = 8'h3C;
        res_set[0] = 3'h7;
        starts = 0;
        repeat (40) begin
            tick();
            starts += int'(conv_start === 1'b1);
        end
        chk("restarts", 8'h00, 8'(starts));
        check_all();
        for (int i = 0; i < 10; i++) begin
            write(4'(i), 8'hFF);
            chk("bus write", MASKS[i], field(i));
        end
        write(4'hA, 8'h00);
        for (int i = 0; i < 10; i++)
            chk("bad field", MASKS[i], field(i));
        rail = 1'b0;
        tick();
        chk("enable drop", 8'h00, 8'(en));
        tick();
        chk("valid drop", 8'h00, 8'(valid));
        write(4'h7, 8'h00);
        chk("early write", 8'hFF, max_load_current);
        sel = 1'b0;
        delay = 4'h0;
        calc_strap();
        for (int i = 0; i < 10; i++)
            exp_f[i] = nvm[i] & MASKS[i];
        power_up();
        check_all();
        chk("stored mode", 8'h00, 8'(strap_act));
        rail = 1'b0;
        repeat (2) tick();
        sel = 1'b1;
        delay = 4'h3;
        calc_strap();
        power_up();
        check_all();
        results();
    end
endmodule : pinstrap_config_capture_bench

/* File: pinstrap_consts.svh */
/*
 * Constants for the pinstrap capture block: timing, widths, field
 * indices, field masks and mode bit positions.
 * Assumes a 200 MHz clock and 8-bit strap voltage conversions.
 */
`ifndef PINSTRAP_CONSTS_SVH
`define PINSTRAP_CONSTS_SVH

`define CLK_PERIOD_NS 5
`define SETTLE_TIME_NS 10000
`define SETTLE_CYCLES (`SETTLE_TIME_NS / `CLK_PERIOD_NS)
`define SETTLE_CNT_W 12

`define ADC_W 8
`define RES_W 3
`define CFG_W 8
`define NUM_FIELDS 10
`define FIELD_SEL_W 4

`define F_SLEW 4'h0
`define F_MODE 4'h1
`define F_OSR 4'h2
`define F_USR 4'h3
`define F_STARTUP_VOLTAGE_STRAP 4'h4
`define F_SOFTSTART_RISE_RATE 4'h5
`define F_FREQ 4'h6
`define FREQUENCY_CURRENT_STRAP 4'h7
`define F_OCL 4'h8
`define F_RAMP 4'h9

`define MASK_SLEW 8'h07
`define MASK_MODE 8'hD8
`define MASK_OSR 8'h07
`define MASK_USR 8'h07
`define MASK_STARTUP_VOLTAGE_STRAP 8'hFF
`define MASK_SOFTSTART_RISE_RATE 8'h03
`define MASK_FREQ 8'h07
`define MASK_MAX_LOAD_CURRENT 8'hFF
`define MASK_OCL 8'h0F
`define MASK_RAMP 8'h03

`define MODE_DAC_BIT 7
`define MODE_ILV_BIT 6
`define MODE_DPS_BIT 4
`define MODE_ZLL_BIT 3

`define CFG_RESET 8'h00
`define ADDR_RESET 4'h0

`endif

/* File: pinstrap_pkg.sv */
/*
 * Types shared by the pinstrap capture block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pinstrap_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_RUN = 2'b11
    } cap_state_t;
    typedef logic [7:0] cfg_word_t;
endpackage : pinstrap_pkg

/* File: strap_level_quantizer.sv */
/*
 * Rounds an 8-bit strap voltage ratio to an OUT_W-bit level code.
 * Assumes the input is already a synchronous conversion result.
 */
`include "pinstrap_consts.svh"
module strap_level_quantizer #(
    parameter int OUT_W = 4
) (
    input wire logic [`ADC_W-1:0] ratio,
    output logic [OUT_W-1:0] level
);
    localparam int SHIFT = `ADC_W - OUT_W;
    localparam logic [`ADC_W:0] HALF = (`ADC_W+1)'((2 ** SHIFT) / 2);

    logic [`ADC_W:0] sum;
    logic [`ADC_W:0] shifted;

    always_comb begin
        sum = {1'b0, ratio} + HALF;
        shifted = sum >> SHIFT;
        // Top level saturates instead of wrapping to zero
        if (shifted[OUT_W]) begin
            level = {OUT_W{1'b1}};
        end else begin
            level = shifted[OUT_W-1:0];
        end
    end
endmodule : strap_level_quantizer

/* File: strap_network_model.sv */
/*
 * Model of the strap resistors, dividers and their converters.
 * Assumes one conv_start pulse per power-up from the capture block.
 */
module strap_network_model (
    input wire logic clk,
    input wire logic conv_start,
    input wire logic [3:0] delay,
    input wire logic [2:0] res_set [6],
    input wire logic [7:0] div_set [6],
    output logic conv_done,
    output logic [2:0] res_o [6],
    output logic [7:0] div_o [6]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_r = 1'b0;
    logic [3:0] wait_r = 4'h0;
    logic [7:0] noise_r = 8'h5A;
    initial conv_done = 1'b0;
    always @(posedge clk) begin
        noise_r <= noise_r + 8'h3B;
        conv_done <= 1'b0;
        if (conv_start) begin
            busy_r <= 1'b1;
            wait_r <= 4'h0;
        end else if (busy_r) begin
            wait_r <= wait_r + 4'h1;
            if (wait_r == delay) begin
                busy_r <= 1'b0;
                conv_done <= 1'b1;
            end
        end
    end
    // Codes only valid in the done cycle; garbage otherwise
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            res_o[i] = conv_done ? res_set[i] : noise_r[2:0] ^ 3'(i);
            div_o[i] = conv_done ? div_set[i] : noise_r + 8'(i);
        end
    end
endmodule : strap_network_model
